// ==== design/abs_board.sv ====
`timescale 1ns/10ps
`include "abs_cfg.svh"
// Operation
// - sixteen inputs converted in turn, one converter
// - channel-to-channel interval set by register
// - master starts full scan every 200 us
// - scan clock out; slave follows external clock
// - 2048-sample buffer holds results until read
// - interrupts at one-eighth and half full
// - interrupt line is shared, pulled low
// - host polls buffer flags every 6.4 ms
// - all transfers by register reads and writes
// - eight 12-bit outputs; outputs 0 to 6 update on write, output 7 has no reachable address
// - four digital lines, per-line direction
// - host drives first line for track/slew
// - host drives second line as focus enable
module abs_board #(
  parameter int DEPTH     = 2048,
  parameter int SCAN_CYC  = `ABS_SCAN_US * `ABS_CLK_MHZ,
  parameter int NCHAN     = 16
) (
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // host link
  abs_link_if.dev           lnk,
  // converter
  output logic              adc_start,
  output logic [3:0]        adc_chan,
  input  wire logic         adc_done,
  input  wire logic [15:0]  adc_data,
  // scan clock
  output logic              scan_clk_out,
  input  wire logic         scan_clk_in,
  // output converters
  output logic [8*12-1:0]   dac_data,
  output logic [7:0]        dac_load,
  // digital lines
  input  wire logic [3:0]   dio_in,
  output logic [3:0]        dio_out,
  output logic [3:0]        dio_oe_n
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [15:0] GAP_RST = 16'(`ABS_GAP_US * `ABS_CLK_MHZ);
  localparam logic [AW:0] EIGHTH  = (AW+1)'(DEPTH / 8);
  localparam logic [AW:0] HALF    = (AW+1)'(DEPTH / 2);

  logic [15:0]     ctrl;
  logic [15:0]     gap;
  logic [3:0]      ev;
  logic [3:0]      ien;
  logic [3:0]      dir;
  logic [15:0]     mem [DEPTH];
  logic [AW-1:0]   wp;
  logic [AW-1:0]   rp;
  logic [AW:0]     fill;
  logic [2:0]      done_s;
  logic [2:0]      ext_s;
  logic [1:0]      din_s [4];
  logic [15:0]     gap_cnt;
  logic [31:0]     scan_cnt;
  logic [15:0]     sample;
  abs_pkg::abs_seq_t sq;

  wire wr_acc = lnk.sel & lnk.wr;
  wire rd_acc = lnk.sel & ~lnk.wr;
  wire done_rise = done_s[1] & ~done_s[2];
  wire ext_rise  = ext_s[1] & ~ext_s[2];
  wire full  = fill[AW];
  wire empty = (fill == '0);
  wire pop   = rd_acc && (lnk.addr == `ABS_R_DATA) && !empty;
  wire push  = (sq == abs_pkg::SQ_WAIT) && done_rise && !full;
  wire int_trig = (scan_cnt == 32'(SCAN_CYC - 1));
  // slave board follows the external clock
  wire trig = ctrl[`ABS_C_EXT] ? ext_rise : int_trig;
  wire [3:0] lvl = {empty, (sq == abs_pkg::SQ_WAIT) && done_rise && full,
                    fill >= HALF, fill >= EIGHTH};
  logic [3:0] lvl_q;

  function automatic logic [3:0] din_now();
    logic [3:0] v;
    v = '0;
    for (int i = 0; i < 4; i++) v[i] = din_s[i][1];
    return v;
  endfunction

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_s <= '0;
      ext_s  <= '0;
      for (int i = 0; i < 4; i++) din_s[i] <= '0;
    end else begin
      done_s <= {done_s[1:0], adc_done};
      ext_s  <= {ext_s[1:0], scan_clk_in};
      for (int i = 0; i < 4; i++) din_s[i] <= {din_s[i][0], dio_in[i]};
    end
  end

  // ----------------------------------------
  // scan pacing
  // ----------------------------------------
  // scan period counter, held at zero while run is clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) scan_cnt <= '0;
    else if (int_trig || !ctrl[`ABS_C_RUN]) scan_cnt <= '0;
    else scan_cnt <= scan_cnt + 32'h0000_0001;
  end

  // scan clock pin pulses at each internal scan start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) scan_clk_out <= 1'b0;
    else scan_clk_out <= int_trig && ctrl[`ABS_C_RUN];
  end

  // ----------------------------------------
  // channel sequencer
  // ----------------------------------------
  // one converter, channels strictly in turn
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sq        <= abs_pkg::SQ_IDLE;
      adc_chan  <= '0;
      adc_start <= 1'b0;
    end else begin
      adc_start <= 1'b0;
      unique case (sq)
        abs_pkg::SQ_IDLE: if (trig && ctrl[`ABS_C_RUN]) begin
          adc_chan <= '0;
          sq       <= abs_pkg::SQ_START;
        end
        abs_pkg::SQ_START: begin
          adc_start <= 1'b1;
          sq        <= abs_pkg::SQ_WAIT;
        end
        abs_pkg::SQ_WAIT: if (done_rise) begin
          sq <= (adc_chan == 4'(NCHAN - 1)) ? abs_pkg::SQ_IDLE : abs_pkg::SQ_GAP;
        end
        abs_pkg::SQ_GAP: if (gap_cnt >= gap - 16'h0001) begin
          adc_chan <= adc_chan + 4'h1;
          sq       <= abs_pkg::SQ_START;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) gap_cnt <= '0;
    else if (sq == abs_pkg::SQ_START) gap_cnt <= 16'h0001;
    else if (gap_cnt != 16'hFFFF) gap_cnt <= gap_cnt + 16'h0001;
  end

  // ----------------------------------------
  // sample buffer
  // ----------------------------------------
  // samples held until host reads them
  always_ff @(posedge hclk) begin
    if (push) mem[wp] <= adc_data;
  end

  // ring buffer, oldest sample out first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp   <= '0;
      rp   <= '0;
      fill <= '0;
    end else begin
      if (push) wp <= wp + AW'(1);
      if (pop) rp <= rp + AW'(1);
      if (push && !pop) fill <= fill + (AW+1)'(1);
      else if (pop && !push) fill <= fill - (AW+1)'(1);
    end
  end

  // ----------------------------------------
  // events and shared interrupt
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) lvl_q <= 4'h9;
    else lvl_q <= lvl;
  end

  // threshold crossings set sticky bits, set beats clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ev <= '0;
    else begin
      for (int i = 0; i < 4; i++) begin
        if (lvl[i] && !lvl_q[i]) ev[i] <= 1'b1;
        else if (wr_acc && lnk.addr == `ABS_R_CLR && lnk.wdata[i]) ev[i] <= 1'b0;
      end
    end
  end

  // pull shared line low while an enabled event stands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lnk.irq_o    <= 1'b1;
      lnk.irq_oe_n <= 1'b1;
    end else begin
      lnk.irq_o    <= 1'b0;
      lnk.irq_oe_n <= ~|(ev & ien);
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  // everything reached through register accesses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= '0;
      gap  <= GAP_RST;
      ien  <= '0;
      dir  <= '0;
      dio_out <= '0;
    end else if (wr_acc) begin
      unique case (lnk.addr)
        `ABS_R_CTRL: ctrl <= lnk.wdata;
        `ABS_R_GAP:  gap  <= (lnk.wdata == '0) ? 16'h0001 : lnk.wdata;
        `ABS_R_IEN:  ien  <= lnk.wdata[3:0];
        `ABS_R_DIR:  dir  <= lnk.wdata[3:0];
        `ABS_R_DIO:  dio_out <= lnk.wdata[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) dio_oe_n <= 4'hF;
    else dio_oe_n <= ~dir;
  end

  // output converter takes value on write, holds it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dac_data <= '0;
      dac_load <= '0;
    end else begin
      for (int i = 0; i < `ABS_DAC_N; i++) begin
        dac_load[i] <= wr_acc && ({1'b0, lnk.addr} == 5'(`ABS_R_DAC0 + i));
        if (wr_acc && {1'b0, lnk.addr} == 5'(`ABS_R_DAC0 + i)) dac_data[i*12 +: 12] <= lnk.wdata[11:0];
      end
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  always_comb begin
    sample = mem[rp];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lnk.ack   <= 1'b0;
      lnk.rdata <= '0;
    end else begin
      lnk.ack <= lnk.sel;
      if (rd_acc) begin
        unique case (lnk.addr)
          `ABS_R_CTRL: lnk.rdata <= ctrl;
          `ABS_R_GAP:  lnk.rdata <= gap;
          `ABS_R_STAT: lnk.rdata <= {12'h000, ev | {empty, 1'b0, lvl[1:0]}};
          `ABS_R_IEN:  lnk.rdata <= {12'h000, ien};
          `ABS_R_FILL: lnk.rdata <= 16'(fill);
          `ABS_R_DATA: lnk.rdata <= empty ? 16'h0000 : sample;
          `ABS_R_DIR:  lnk.rdata <= {12'h000, dir};
          `ABS_R_DIO:  lnk.rdata <= {12'h000, (dir & dio_out) | (~dir & din_now())};
          default:     lnk.rdata <= 16'h0000;
        endcase
      end
    end
  end
endmodule

// ==== design/abs_cfg.svh ====
`ifndef ABS_CFG_SVH
`define ABS_CFG_SVH
// ----------------------------------------
// board register indices (link address)
// ----------------------------------------
`define ABS_R_CTRL   4'h0
`define ABS_R_GAP    4'h1
`define ABS_R_STAT   4'h2
`define ABS_R_CLR    4'h3
`define ABS_R_IEN    4'h4
`define ABS_R_FILL   4'h5
`define ABS_R_DATA   4'h6
`define ABS_R_DIR    4'h7
`define ABS_R_DIO    4'h8
`define ABS_R_DAC0   4'h9
`define ABS_DAC_N    8
// ----------------------------------------
// board field positions
// ----------------------------------------
`define ABS_C_RUN    0
`define ABS_C_EXT    1
`define ABS_S_EIGHTH 0
`define ABS_S_HALF   1
`define ABS_S_OVF    2
`define ABS_S_EMPTY  3
// ----------------------------------------
// timing
// ----------------------------------------
`define ABS_CLK_MHZ  100
`define ABS_GAP_US   5
`define ABS_SCAN_US  200
`define ABS_POLL_US  6400
// ----------------------------------------
// controller ahb map (byte address)
// ----------------------------------------
`define ABS_H_STAT   8'h00
`define ABS_H_CLR    8'h04
`define ABS_H_IEN    8'h08
`define ABS_H_CMD    8'h0C
`define ABS_H_RES    8'h10
`define ABS_H_CTRL   8'h14
`define ABS_H_POLL   8'h18
`define ABS_E_THR    0
`define ABS_E_CMD    1
`define ABS_K_TRACK  0
`define ABS_K_FOCUS  1
`define ABS_K_POLL   2
`define ABS_DIR_INIT 4'h3
`endif

// ==== design/abs_ctl.sv ====
`timescale 1ns/10ps
`include "abs_cfg.svh"
module abs_ctl #(
  parameter int POLL_CYC = `ABS_POLL_US * `ABS_CLK_MHZ
) (
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // ahb-lite slave
  input  wire logic         hsel,
  input  wire logic [7:0]   haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic         hready,
  input  wire logic [31:0]  hwdata,
  output logic [31:0]       hrdata,
  output logic              hreadyout,
  output logic              hresp,
  output logic              irq,
  // board link
  abs_link_if.host          lnk
);
  logic [1:0]   ev;
  logic [1:0]   ien;
  logic [2:0]   ctl;
  logic [31:0]  cmd;
  logic [15:0]  res;
  logic [15:0]  pflags;
  logic         p_cmd;
  logic         p_dir;
  logic         p_dio;
  logic         p_poll;
  logic [31:0]  pcnt;
  logic         a_wr;
  logic [7:0]   a_addr;
  abs_pkg::abs_hop_t  op;
  abs_pkg::abs_kind_t kind;

  wire a_take = hsel & htrans[1] & hready;
  wire w_en   = a_wr;
  wire busy   = (op != abs_pkg::HO_IDLE);
  wire done   = (op == abs_pkg::HO_WAIT) && lnk.ack;
  wire thr    = |lnk.rdata[`ABS_S_HALF:`ABS_S_EIGHTH];

  // ----------------------------------------
  // ahb-lite slave, zero wait
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_wr      <= 1'b0;
      a_addr    <= '0;
      hrdata    <= '0;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      a_wr      <= a_take & hwrite;
      a_addr    <= haddr;
      if (a_take && !hwrite) begin
        unique case (haddr)
          `ABS_H_STAT: hrdata <= {30'h0000_0000, ev};
          `ABS_H_IEN:  hrdata <= {30'h0000_0000, ien};
          `ABS_H_CMD:  hrdata <= cmd;
          `ABS_H_RES:  hrdata <= {15'h0000, p_cmd, res};
          `ABS_H_CTRL: hrdata <= {29'h0000_0000, ctl};
          `ABS_H_POLL: hrdata <= {16'h0000, pflags};
          default:     hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ien <= '0;
      ctl <= '0;
      cmd <= '0;
    end else if (w_en) begin
      if (a_addr == `ABS_H_IEN) ien <= hwdata[1:0];
      if (a_addr == `ABS_H_CTRL) ctl <= hwdata[2:0];
      if (a_addr == `ABS_H_CMD && !p_cmd) cmd <= hwdata;
    end
  end

  // ----------------------------------------
  // sticky events and interrupt
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ev <= '0;
    else begin
      if (done && kind == abs_pkg::HK_POLL && thr) ev[`ABS_E_THR] <= 1'b1;
      else if (w_en && a_addr == `ABS_H_CLR && hwdata[`ABS_E_THR]) ev[`ABS_E_THR] <= 1'b0;
      if (done && kind == abs_pkg::HK_CMD) ev[`ABS_E_CMD] <= 1'b1;
      else if (w_en && a_addr == `ABS_H_CLR && hwdata[`ABS_E_CMD]) ev[`ABS_E_CMD] <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) irq <= 1'b0;
    else irq <= |(ev & ien);
  end

  // ----------------------------------------
  // poll timer
  // ----------------------------------------
  // flags read every poll period instead of interrupts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) pcnt <= '0;
    else if (!ctl[`ABS_K_POLL] || pcnt == 32'(POLL_CYC - 1)) pcnt <= '0;
    else pcnt <= pcnt + 32'h0000_0001;
  end

  // ----------------------------------------
  // pending work, set beats take
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p_cmd  <= 1'b0;
      p_dir  <= 1'b1;
      p_dio  <= 1'b0;
      p_poll <= 1'b0;
    end else begin
      if (w_en && a_addr == `ABS_H_CMD && !p_cmd) p_cmd <= 1'b1;
      else if (done && kind == abs_pkg::HK_CMD) p_cmd <= 1'b0;
      if (done && kind == abs_pkg::HK_DIR) p_dir <= 1'b0;
      if (w_en && a_addr == `ABS_H_CTRL) p_dio <= 1'b1;
      else if (done && kind == abs_pkg::HK_DIO) p_dio <= 1'b0;
      if (ctl[`ABS_K_POLL] && pcnt == 32'(POLL_CYC - 1)) p_poll <= 1'b1;
      else if (done && kind == abs_pkg::HK_POLL) p_poll <= 1'b0;
    end
  end

  // ----------------------------------------
  // link operations
  // ----------------------------------------
  // track and focus enable driven as outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op        <= abs_pkg::HO_IDLE;
      kind      <= abs_pkg::HK_CMD;
      lnk.sel   <= 1'b0;
      lnk.wr    <= 1'b0;
      lnk.addr  <= '0;
      lnk.wdata <= '0;
      res       <= '0;
      pflags    <= '0;
    end else begin
      lnk.sel <= 1'b0;
      if (!busy) begin
        if (p_dir) begin
          kind <= abs_pkg::HK_DIR;
          lnk.sel <= 1'b1; lnk.wr <= 1'b1; lnk.addr <= `ABS_R_DIR;
          lnk.wdata <= {12'h000, `ABS_DIR_INIT};
          op <= abs_pkg::HO_WAIT;
        end else if (p_cmd) begin
          kind <= abs_pkg::HK_CMD;
          lnk.sel <= 1'b1; lnk.wr <= cmd[4]; lnk.addr <= cmd[3:0];
          lnk.wdata <= cmd[31:16];
          op <= abs_pkg::HO_WAIT;
        end else if (p_dio) begin
          kind <= abs_pkg::HK_DIO;
          lnk.sel <= 1'b1; lnk.wr <= 1'b1; lnk.addr <= `ABS_R_DIO;
          lnk.wdata <= {14'h0000, ctl[`ABS_K_FOCUS], ctl[`ABS_K_TRACK]};
          op <= abs_pkg::HO_WAIT;
        end else if (p_poll) begin
          kind <= abs_pkg::HK_POLL;
          lnk.sel <= 1'b1; lnk.wr <= 1'b0; lnk.addr <= `ABS_R_STAT;
          op <= abs_pkg::HO_WAIT;
        end
      end else if (done) begin
        op <= abs_pkg::HO_IDLE;
        if (kind == abs_pkg::HK_CMD) res <= lnk.rdata;
        if (kind == abs_pkg::HK_POLL) pflags <= lnk.rdata;
      end
    end
  end
endmodule

// ==== design/abs_link_if.sv ====
`timescale 1ns/10ps
interface abs_link_if (
  input wire logic hclk
);
  logic        sel;
  logic        wr;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        ack;
  logic        irq_o;
  logic        irq_oe_n;
  wire         irq_line;
  // released shared line reads high
  assign irq_line = irq_oe_n ? 1'b1 : irq_o;
  modport dev  (input sel, wr, addr, wdata, output rdata, ack, irq_o, irq_oe_n);
  modport host (output sel, wr, addr, wdata, input rdata, ack);
endinterface

// ==== design/abs_pkg.sv ====
package abs_pkg;
  typedef enum logic [1:0] {SQ_IDLE, SQ_START, SQ_WAIT, SQ_GAP} abs_seq_t;
  typedef enum logic [1:0] {HO_IDLE, HO_WAIT} abs_hop_t;
  typedef enum logic [1:0] {HK_CMD, HK_DIR, HK_DIO, HK_POLL} abs_kind_t;
endpackage

// ==== tb/abs_link_props.sv ====
`timescale 1ns/10ps
`include "abs_cfg.svh"
module abs_link_props (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // board link
  input wire logic        sel,
  input wire logic        wr,
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic        ack,
  input wire logic        irq_o,
  input wire logic        irq_oe_n,
  input wire              irq_line
);
  logic       rd_q;
  logic       seen;
  logic [3:0] cnt;

  // ----------------------------------------
  // helper state
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 1'b0;
    end else begin
      rd_q <= sel & ~wr;
    end
  end

  // first link op seen, cycles waited for it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen <= 1'b0;
      cnt  <= 4'h0;
    end else begin
      seen <= seen | sel;
      if (!seen && cnt != 4'hF) begin
        cnt <= cnt + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_ack_follows_sel:
    assert property (sel |=> ack) else $error("no ack one cycle after select");
  chk_ack_has_cause:
    assert property (ack |-> $past(sel)) else $error("ack without select");
  chk_sel_single_pulse:
    assert property (sel |=> !sel) else $error("select held two cycles");
  chk_rdata_on_read:
    assert property ($changed(rdata) |-> ack && rd_q) else $error("read data moved outside a read");
  chk_irq_drive_low:
    assert property (!irq_oe_n |-> !irq_o) else $error("interrupt driven high");
  chk_irq_line_source:
    assert property (!irq_line |-> !irq_oe_n && !irq_o) else $error("interrupt line low while released");
  chk_dir_init_first:
    assert property (sel && !seen |-> wr && addr == `ABS_R_DIR && wdata == 16'h0003)
      else $error("first link op is not the direction setup");
  chk_dir_init_soon:
    assert property (!seen |-> cnt < 4'h4) else $error("direction setup late");
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`include "abs_cfg.svh"
module tb_top;
  typedef struct packed {
    logic        w;
    logic [3:0]  a;
    logic [15:0] d;
    logic [15:0] e;
  } abs_row_t;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata;
  logic        adc_start, adc_done, scan_clk_out, scan_clk_in;
  logic [3:0]  adc_chan, dio_in, dio_out, dio_oe_n;
  logic [15:0] adc_data;
  logic [95:0] dac_data;
  logic [7:0]  dac_load;
  int          mismatches, cmp_count, nconv, cyc, last_sc, last_st, cur, ph, nld0;

  abs_link_if u_abs_link_if (.hclk(hclk));
  abs_board #(.DEPTH(64), .SCAN_CYC(2000)) u_abs_board (.hclk(hclk), .hresetn(hresetn),
    .lnk(u_abs_link_if.dev), .adc_start(adc_start), .adc_chan(adc_chan), .adc_done(adc_done),
    .adc_data(adc_data), .scan_clk_out(scan_clk_out), .scan_clk_in(scan_clk_in), .dac_data(dac_data),
    .dac_load(dac_load), .dio_in(dio_in), .dio_out(dio_out), .dio_oe_n(dio_oe_n));
  abs_ctl #(.POLL_CYC(64)) u_abs_ctl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .lnk(u_abs_link_if.host));
  abs_link_props u_abs_link_props (.hclk(hclk), .hresetn(hresetn), .sel(u_abs_link_if.sel),
    .wr(u_abs_link_if.wr), .addr(u_abs_link_if.addr), .wdata(u_abs_link_if.wdata),
    .rdata(u_abs_link_if.rdata), .ack(u_abs_link_if.ack), .irq_o(u_abs_link_if.irq_o),
    .irq_oe_n(u_abs_link_if.irq_oe_n), .irq_line(u_abs_link_if.irq_line));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic tick(inout int n);
    @(posedge hclk);
    n++;
    if (n > 6000) begin
      mismatches++;
      tally_and_finish();
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'b010;
    tick(n);
    while (hreadyout !== 1'b1) tick(n);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    tick(n);
    while (hreadyout !== 1'b1) tick(n);
    r = hrdata;
  endtask

  // one board access through the command register
  task automatic lnk(input logic w, input logic [3:0] a, input logic [15:0] d, output logic [15:0] r);
    logic [31:0] v;
    int          n;
    n = 0;
    ahb(1'b1, `ABS_H_CMD, {d, 11'h000, w, a}, v);
    tick(n);
    ahb(1'b0, `ABS_H_RES, 32'h0000_0000, v);
    while (v[16] !== 1'b0) begin
      tick(n);
      ahb(1'b0, `ABS_H_RES, 32'h0000_0000, v);
    end
    r = v[15:0];
  endtask

  task automatic wait_conv(input int t);
    int n;
    n = 0;
    while (nconv < t) tick(n);
    repeat (20) @(posedge hclk);
  endtask

  // ----------------------------------------
  // converter stand-in and scan timing
  // ----------------------------------------
  always @(posedge hclk) begin
    cyc++;
    if (dac_load[0] === 1'b1) nld0++;
    if (scan_clk_out === 1'b1) begin
      if (last_sc != 0) chk(cyc - last_sc, 2000);
      last_sc = cyc;
    end
    if (adc_start === 1'b1) begin
      chk(32'(adc_chan), 32'(nconv % 16));
      if (nconv % 16 != 0) chk(cyc - last_st, 20);
      last_st = cyc;
      cur = nconv;
      nconv++;
      ph = 1;
    end else if (ph != 0) begin
      ph++;
    end
    if (ph == 3) adc_data <= {cur[3:0], cur[11:0]};
    if (ph == 4) adc_done <= 1'b1;
    if (ph == 10) begin
      adc_done <= 1'b0;
      adc_data <= ~adc_data;
      ph = 0;
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [15:0] r;
    logic [31:0] v;
    abs_row_t    rows [15];
    rows = '{'{1'b0, `ABS_R_GAP, 16'h0000, 16'h01F4}, '{1'b1, `ABS_R_GAP, 16'h0000, 16'h0000},
             '{1'b0, `ABS_R_GAP, 16'h0000, 16'h0001}, '{1'b1, `ABS_R_GAP, 16'h0014, 16'h0000},
             '{1'b0, `ABS_R_GAP, 16'h0000, 16'h0014}, '{1'b0, `ABS_R_DIR, 16'h0000, 16'h0003},
             '{1'b1, `ABS_R_DIR, 16'h000F, 16'h0000}, '{1'b1, `ABS_R_DIO, 16'h0005, 16'h0000},
             '{1'b0, `ABS_R_DIO, 16'h0000, 16'h0005}, '{1'b1, `ABS_R_DIR, 16'h0000, 16'h0000},
             '{1'b0, `ABS_R_DIO, 16'h0000, 16'h000A}, '{1'b1, `ABS_R_DIR, 16'h0003, 16'h0000},
             '{1'b0, `ABS_R_FILL, 16'h0000, 16'h0000}, '{1'b0, `ABS_R_DATA, 16'h0000, 16'h0000},
             '{1'b0, `ABS_R_STAT, 16'h0000, 16'h0008}};
    hresetn = 1'b0;
    {hsel, hwrite, adc_done, scan_clk_in, htrans, hsize, haddr, hwdata, adc_data} = '0;
    dio_in = 4'hA;
    repeat (16) @(posedge hclk);
    chk(32'(dio_oe_n), 32'h0000_000F);
    chk(32'(u_abs_link_if.irq_line), 32'h0000_0001);
    chk(32'(hreadyout), 32'h0000_0000);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    foreach (rows[i]) begin
      lnk(rows[i].w, rows[i].a, rows[i].d, r);
      if (!rows[i].w) chk(32'(r), 32'(rows[i].e));
    end
    chk(32'(dio_oe_n), 32'h0000_000C);
    $display("test registers done");
    lnk(1'b1, `ABS_R_CTRL, 16'h0001, r);
    wait_conv(32);
    lnk(1'b1, `ABS_R_CTRL, 16'h0000, r);
    lnk(1'b0, `ABS_R_FILL, 16'h0000, r);
    chk(32'(r), 32'h0000_0020);
    lnk(1'b0, `ABS_R_STAT, 16'h0000, r);
    chk(32'(r), 32'h0000_0003);
    lnk(1'b1, `ABS_R_IEN, 16'h0003, r);
    chk(32'(u_abs_link_if.irq_line), 32'h0000_0000);
    lnk(1'b1, `ABS_R_IEN, 16'h0000, r);
    chk(32'(u_abs_link_if.irq_line), 32'h0000_0001);
    lnk(1'b1, `ABS_R_IEN, 16'h0003, r);
    lnk(1'b1, `ABS_R_CLR, 16'h0003, r);
    chk(32'(u_abs_link_if.irq_line), 32'h0000_0001);
    $display("test scan done");
    ahb(1'b1, `ABS_H_CTRL, 32'h0000_0007, v);
    repeat (200) @(posedge hclk);
    chk(32'(dio_out[1:0]), 32'h0000_0003);
    ahb(1'b0, `ABS_H_POLL, 32'h0000_0000, v);
    chk({16'h0000, v[15:0]}, 32'h0000_0003);
    ahb(1'b0, `ABS_H_STAT, 32'h0000_0000, v);
    chk(32'(v[0]), 32'h0000_0001);
    ahb(1'b1, `ABS_H_IEN, 32'h0000_0001, v);
    repeat (2) @(posedge hclk);
    chk(32'(irq), 32'h0000_0001);
    ahb(1'b1, `ABS_H_CTRL, 32'h0000_0001, v);
    repeat (200) @(posedge hclk);
    chk(32'(dio_out[1:0]), 32'h0000_0001);
    ahb(1'b0, `ABS_H_CTRL, 32'h0000_0000, v);
    chk(v, 32'h0000_0001);
    chk(32'(hresp), 32'h0000_0000);
    ahb(1'b1, `ABS_H_CLR, 32'h0000_0001, v);
    repeat (2) @(posedge hclk);
    chk(32'(irq), 32'h0000_0000);
    $display("test controller done");
    last_sc = 0;
    lnk(1'b1, `ABS_R_CTRL, 16'h0003, r);
    repeat (3) begin
      scan_clk_in <= 1'b1;
      repeat (2) @(posedge hclk);
      scan_clk_in <= 1'b0;
      repeat (400) @(posedge hclk);
    end
    wait_conv(80);
    lnk(1'b0, `ABS_R_FILL, 16'h0000, r);
    chk(32'(r), 32'h0000_0040);
    lnk(1'b0, `ABS_R_STAT, 16'h0000, r);
    chk(32'(r), 32'h0000_0007);
    for (int k = 0; k < 64; k++) begin
      lnk(1'b0, `ABS_R_DATA, 16'h0000, r);
      chk(32'(r), {16'h0000, k[3:0], k[11:0]});
    end
    lnk(1'b0, `ABS_R_DATA, 16'h0000, r);
    chk(32'(r), 32'h0000_0000);
    lnk(1'b0, `ABS_R_STAT, 16'h0000, r);
    chk(32'(r), 32'h0000_000C);
    $display("test overflow done");
    lnk(1'b1, `ABS_R_DAC0, 16'h0ABC, r);
    chk(32'(dac_data[11:0]), 32'h0000_0ABC);
    lnk(1'b1, `ABS_R_DAC0 + 4'h3, 16'h0123, r);
    chk(32'(dac_data[47:36]), 32'h0000_0123);
    chk(32'(dac_data[11:0]), 32'h0000_0ABC);
    chk(nld0, 1);
    $display("test outputs done");
    tally_and_finish();
  end
endmodule
